//--- core/mam_core.sv
`timescale 1ns/10ps
// Overview of operation
// - Sources are 36 hardware inputs and 36 playback channels; 36 outputs.
// - Each output sums every source scaled by its own crosspoint gain.
// - Record data carries hardware inputs untouched unless loopback is on.
// - Source meters read before any gain, output meters after all gains.
// - Every channel gets a peak and an average power level in hardware.
// - Peak has zero attack, one full-scale sample reaches full scale.
// - Peak hold, over criterion and power reference are settings.
// - Pan splits a source over an output pair, -3 dB each side at centre.
// - Each output applies its own output gain after the sum.
// - A crosspoint at minus infinity contributes nothing.
// - With trim on, a source's own relative gain scales all its active crosspoints.
// - Each channel is mono or one half of a stereo pair.
// - Input and playback channels each have a mute.
// - Up to 18 independent stereo submixes, one per output pair.
// - Loopback sends an output's mix to the record stream instead.
module mam_core (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic ce,
    // Source sample stream
    input wire logic in_valid,
    input wire logic [mam_pkg::CW-1:0] in_chan,
    input wire logic [mam_pkg::SW-1:0] in_sample,
    output logic in_ready,
    input wire logic frame_go,
    // Crosspoint gains
    input wire logic gain_wr,
    input wire logic [mam_pkg::OW-1:0] gain_out,
    input wire logic [mam_pkg::CW-1:0] gain_src,
    input wire logic [mam_pkg::GW-1:0] gain_val,
    // Channel settings
    input wire logic src_cfg_wr,
    input wire logic [mam_pkg::CW-1:0] src_sel,
    input wire mam_pkg::mam_src_cfg_type src_cfg,
    input wire logic out_cfg_wr,
    input wire logic [mam_pkg::OW-1:0] out_sel,
    input wire mam_pkg::mam_out_cfg_type out_cfg,
    // Metering settings
    input wire logic [15:0] hold_frames,
    input wire logic [3:0] over_samples,
    input wire logic rms_ref_plus3,
    // Status
    output logic init_done,
    // Output sample stream
    output logic out_valid,
    output logic [mam_pkg::OW-1:0] out_chan,
    output logic [mam_pkg::SW-1:0] out_sample,
    // Record stream
    output logic rec_valid,
    output logic [mam_pkg::OW-1:0] rec_chan,
    output logic [mam_pkg::SW-1:0] rec_sample,
    // Meter stream
    output logic meter_valid,
    output logic [mam_pkg::CW-1:0] meter_chan,
    output mam_pkg::mam_meter_type meter
);
    mam_pkg::mam_state_type state;
    logic ph;
    logic [mam_pkg::OW-1:0] o;
    logic [mam_pkg::CW-1:0] s;
    logic [mam_pkg::CW-1:0] ch;
    logic [mam_pkg::XAW-1:0] init_addr;
    mam_pkg::mam_src_cfg_type src_tab [mam_pkg::N_SRC];
    mam_pkg::mam_out_cfg_type out_tab [mam_pkg::N_OUT];
    logic signed [mam_pkg::SW-1:0] mix_out [mam_pkg::N_OUT];
    logic signed [39:0] acc;
    logic init;
    logic [mam_pkg::GW-1:0] xp_rd;
    logic signed [mam_pkg::SW-1:0] samp_rd;
    mam_pkg::mam_meter_state_type meter_rd;
    mam_pkg::mam_meter_state_type next_meter;

    assign init = (state == mam_pkg::ST_INIT);
    assign init_done = !init;
    assign in_ready = (state == mam_pkg::ST_IDLE);

    function automatic logic [14:0] mam_pan_gain(input logic [8:0] x);
        logic [23:0] bx;
        logic [14:0] diff;
        logic [23:0] g;
        bx = 24'(x) * 24'(mam_pkg::PAN_B);
        diff = mam_pkg::PAN_A - bx[22:8];
        g = 24'(x) * 24'(diff);
        return g[22:8];
    endfunction

    // Crosspoint gains, one word per output and source.
    mam_ram #(.W(mam_pkg::GW), .D(mam_pkg::XP_DEPTH), .AW(mam_pkg::XAW))
    u_xp (
        .clock(clock),
        .ce(ce),
        .wr(init || (gain_wr && 7'(gain_out) < 7'(mam_pkg::N_OUT)
            && gain_src < 7'(mam_pkg::N_SRC))),
        .waddr(init ? init_addr : 12'(gain_out) * mam_pkg::XP_STRIDE
            + 12'(gain_src)),
        .wdata(init ? mam_pkg::GAIN_MINUS_INF : gain_val),
        .raddr(12'(o) * mam_pkg::XP_STRIDE + 12'(s)),
        .rdata(xp_rd)
    );

    // Source samples of the current frame.
    mam_ram #(.W(mam_pkg::SW), .D(mam_pkg::N_SRC), .AW(mam_pkg::CW)) u_smp (
        .clock(clock),
        .ce(ce),
        .wr(init ? init_addr < 12'(mam_pkg::N_SRC)
            : in_valid && in_ready && in_chan < 7'(mam_pkg::N_SRC)),
        .waddr(init ? init_addr[6:0] : in_chan),
        .wdata(init ? '0 : in_sample),
        .raddr(state == mam_pkg::ST_METER ? ch : s),
        .rdata(samp_rd)
    );

    // Meter state for every channel.
    mam_ram #(.W($bits(mam_pkg::mam_meter_state_type)),
        .D(mam_pkg::N_METER), .AW(mam_pkg::CW)) u_mtr (
        .clock(clock),
        .ce(ce),
        .wr(init ? init_addr < 12'(mam_pkg::N_METER)
            : state == mam_pkg::ST_METER && ph),
        .waddr(init ? init_addr[6:0] : ch),
        .wdata(init ? '0 : next_meter),
        .raddr(ch),
        .rdata(meter_rd)
    );

    // Crosspoint coefficient for source s into output o.
    mam_pkg::mam_src_cfg_type sc;
    logic [31:0] trim_p;
    logic [17:0] coef_t;
    logic [8:0] pan_x;
    logic [14:0] pan_g;
    logic [32:0] pan_p;
    logic [17:0] coef;
    logic signed [42:0] prod;
    logic signed [28:0] contrib;
    always_comb begin
        sc = src_tab[s];
        trim_p = 32'(xp_rd) * 32'(sc.trim);
        coef_t = sc.trim_en ? trim_p[31:14] : {2'h0, xp_rd};
        pan_x = o[0] ? {1'b0, sc.pan}
            : mam_pkg::PAN_SPAN - {1'b0, sc.pan};
        pan_g = mam_pan_gain(pan_x);
        pan_p = 33'(coef_t) * 33'(pan_g);
        if (out_tab[o].stereo && !sc.stereo) begin
            coef = pan_p[31:14];
        end else if (out_tab[o].stereo && s[0] != o[0]) begin
            coef = '0;
        end else begin
            coef = coef_t;
        end
        if (sc.mute || xp_rd == mam_pkg::GAIN_MINUS_INF) begin
            coef = '0;
        end
        prod = 43'(samp_rd) * 43'($signed({1'b0, coef}));
        contrib = prod[42:14];
    end

    // Output stage gain and saturation.
    logic signed [56:0] scaled;
    logic [42:0] shifted;
    logic over_mix;
    logic [mam_pkg::SW-1:0] y_sat;
    always_comb begin
        scaled = 57'(acc) * 57'($signed({1'b0, out_tab[o].gain}));
        shifted = scaled[56:14];
        over_mix = !(&shifted[42:23] || ~|shifted[42:23]);
        y_sat = over_mix ? (shifted[42] ? mam_pkg::NEG_MAX : mam_pkg::POS_MAX)
            : shifted[23:0];
    end

    // Meter update; sources are read pre-gain, outputs post-gain.
    logic signed [mam_pkg::SW-1:0] meter_x;
    logic [mam_pkg::SW-1:0] neg_x;
    logic [22:0] mag;
    logic full;
    logic [3:0] over_need;
    logic signed [47:0] sq;
    logic signed [32:0] ms_diff;
    always_comb begin
        meter_x = (ch < 7'(mam_pkg::N_SRC)) ? samp_rd
            : mix_out[6'(ch - 7'(mam_pkg::N_SRC))];
        neg_x = -meter_x;
        mag = !meter_x[23] ? meter_x[22:0] : (neg_x[23]
            ? mam_pkg::FULL_SCALE : neg_x[22:0]);
        full = (mag == mam_pkg::FULL_SCALE);
        over_need = (over_samples == 4'h0) ? 4'h1 : over_samples;
        next_meter = meter_rd;
        if (mag >= meter_rd.peak) begin
            next_meter.peak = mag;
            next_meter.hold = hold_frames;
        end else if (meter_rd.hold != 16'h0000) begin
            next_meter.hold = meter_rd.hold - 16'h0001;
        end else begin
            next_meter.peak = mag;
        end
        if (!full) begin
            next_meter.over_run = 4'h0;
        end else if (meter_rd.over_run != mam_pkg::OVER_RUN_MAX) begin
            next_meter.over_run = meter_rd.over_run + 4'h1;
        end
        next_meter.over = (full && next_meter.over_run >= over_need)
            || (meter_rd.over && meter_rd.hold != 16'h0000);
        sq = 48'(meter_x) * 48'(meter_x);
        ms_diff = $signed({1'b0, sq[46:15]}) - $signed({1'b0, meter_rd.ms});
        next_meter.ms = 32'($signed({1'b0, meter_rd.ms})
            + (ms_diff >>> mam_pkg::MS_SHIFT));
    end

    // Frame sequencer.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= mam_pkg::ST_INIT;
            ph <= 1'b0;
            o <= '0;
            s <= '0;
            ch <= '0;
            init_addr <= '0;
        end else if (ce) begin
            case (state)
                mam_pkg::ST_INIT: begin
                    init_addr <= init_addr + 12'h001;
                    if (init_addr == mam_pkg::XP_LAST) begin
                        state <= mam_pkg::ST_IDLE;
                    end
                end
                mam_pkg::ST_IDLE: begin
                    if (frame_go) begin
                        state <= mam_pkg::ST_MIX;
                        ph <= 1'b0;
                        o <= '0;
                        s <= '0;
                    end
                end
                mam_pkg::ST_MIX: begin
                    ph <= !ph;
                    if (ph) begin
                        if (s == 7'(mam_pkg::N_SRC - 1)) begin
                            s <= '0;
                            state <= mam_pkg::ST_FIN;
                        end else begin
                            s <= s + 7'h01;
                        end
                    end
                end
                mam_pkg::ST_FIN: begin
                    if (o == 6'(mam_pkg::N_OUT - 1)) begin
                        o <= '0;
                        ch <= '0;
                        state <= mam_pkg::ST_METER;
                    end else begin
                        o <= o + 6'h01;
                        state <= mam_pkg::ST_MIX;
                    end
                end
                mam_pkg::ST_METER: begin
                    ph <= !ph;
                    if (ph) begin
                        if (ch == 7'(mam_pkg::N_METER - 1)) begin
                            state <= mam_pkg::ST_IDLE;
                        end else begin
                            ch <= ch + 7'h01;
                        end
                    end
                end
                default: state <= mam_pkg::ST_INIT;
            endcase
        end
    end

    // Accumulator; 40 bits leave ample headroom for 72 full-scale terms.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc <= '0;
        end else if (ce) begin
            if (state == mam_pkg::ST_MIX && ph) begin
                acc <= acc + 40'(contrib);
            end else if (state == mam_pkg::ST_FIN) begin
                acc <= '0;
            end
        end
    end

    // Channel settings tables.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < mam_pkg::N_SRC; i++) begin
                src_tab[i] <= mam_pkg::SRC_CFG_RST;
            end
            for (int i = 0; i < mam_pkg::N_OUT; i++) begin
                out_tab[i] <= mam_pkg::OUT_CFG_RST;
            end
        end else if (ce) begin
            if (src_cfg_wr && src_sel < 7'(mam_pkg::N_SRC)) begin
                src_tab[src_sel] <= src_cfg;
            end
            if (out_cfg_wr && 7'(out_sel) < 7'(mam_pkg::N_OUT)) begin
                out_tab[out_sel] <= out_cfg;
            end
        end
    end

    // Output samples.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < mam_pkg::N_OUT; i++) begin
                mix_out[i] <= '0;
            end
            out_valid <= 1'b0;
            out_chan <= '0;
            out_sample <= '0;
        end else if (ce) begin
            out_valid <= (state == mam_pkg::ST_FIN);
            if (state == mam_pkg::ST_FIN) begin
                mix_out[o] <= y_sat;
                out_chan <= o;
                out_sample <= y_sat;
            end
        end
    end

    // Record and meter streams.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rec_valid <= 1'b0;
            rec_chan <= '0;
            rec_sample <= '0;
            meter_valid <= 1'b0;
            meter_chan <= '0;
            meter <= '0;
        end else if (ce) begin
            rec_valid <= 1'b0;
            meter_valid <= 1'b0;
            if (state == mam_pkg::ST_METER && ph) begin
                meter_valid <= 1'b1;
                meter_chan <= ch;
                meter.peak <= next_meter.peak;
                meter.overload_indicator <= next_meter.over;
                meter.average_power_level <= !rms_ref_plus3 ? next_meter.ms
                    : (next_meter.ms[31] ? 32'hFFFFFFFF
                    : {next_meter.ms[30:0], 1'b0});
                if (ch < 7'(mam_pkg::N_HW)) begin
                    rec_valid <= 1'b1;
                    rec_chan <= ch[5:0];
                    rec_sample <= out_tab[ch[5:0]].loopback
                        ? mix_out[ch[5:0]] : samp_rd;
                end
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    logic mix_step;
    logic meter_step;
    assign mix_step = ce && state == mam_pkg::ST_MIX && ph;
    assign meter_step = ce && state == mam_pkg::ST_METER && ph;

    AST_OUT_RANGE: assert property (out_valid |-> out_chan < 6'h24)
        else $error("output channel out of range");
    AST_SUM: assert property (mix_step |=> acc == $past(acc)
        + 40'($past(contrib))) else $error("sum lost a term");
    AST_REC_RAW: assert property (meter_step && ch < 7'h24
        && !out_tab[ch[5:0]].loopback |=> rec_valid
        && rec_sample == $past(samp_rd)) else $error("record altered");
    AST_OUT_METER: assert property (ce && state == mam_pkg::ST_METER
        && ch >= 7'h48 |-> meter_x == mix_out[6'(ch - 7'h48)])
        else $error("output meter not post gain");
    AST_ZERO_ATTACK: assert property (meter_step && full |=>
        meter_valid && meter.peak == 23'h7FFFFF)
        else $error("full scale peak missed");
    AST_HOLD: assert property (meter_step && mag < meter_rd.peak
        && meter_rd.hold != 16'h0000 |=> meter.peak == $past(meter_rd.peak))
        else $error("peak released during hold");
    AST_PAN_CENTER: assert property (pan_x == 9'h080
        |-> pan_g == 15'h2D41) else $error("pan centre not -3 dB");
    AST_OUT_GAIN: assert property (ce && state == mam_pkg::ST_FIN
        && out_tab[o].gain == 16'h0000 |=> out_valid && out_sample == '0)
        else $error("output gain ignored");
    AST_MINUS_INF: assert property (mix_step && xp_rd == 16'h0000
        |=> acc == $past(acc)) else $error("silent crosspoint leaked");
    AST_MUTE: assert property (mix_step && sc.mute
        |=> acc == $past(acc)) else $error("muted source leaked");
    AST_LOOPBACK: assert property (meter_step && ch < 7'h24
        && out_tab[ch[5:0]].loopback |=> rec_valid
        && rec_sample == mix_out[rec_chan]) else $error("loopback missing");
    AST_SATURATE: assert property (ce && state == mam_pkg::ST_FIN
        && over_mix && !shifted[42] |=> out_sample == 24'h7FFFFF)
        else $error("positive overflow wrapped");

    COV_FRAME: cover property (meter_step && ch == 7'h6B);
    COV_OVER: cover property (meter_valid && meter.overload_indicator);
    COV_LOOP: cover property (meter_step && out_tab[ch[5:0]].loopback
        && ch < 7'h24);
    COV_TRIM: cover property (mix_step && sc.trim_en && coef != '0);
endmodule

//--- core/mam_ram.sv
`timescale 1ns/10ps
module mam_ram #(
    parameter int W = 16,
    parameter int D = 16,
    parameter int AW = 4
) (
    // Clock
    input wire logic clock,
    input wire logic ce,
    // Write port
    input wire logic wr,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [D];

    always_ff @(posedge clock) begin
        if (ce && wr) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (ce) begin
            rdata <= mem[raddr];
        end
    end
endmodule

//--- pkg/mam_pkg.sv
package mam_pkg;
    localparam int N_HW = 36;
    localparam int N_SRC = 72;
    localparam int N_OUT = 36;
    localparam int N_METER = 108;
    localparam int SW = 24;
    localparam int GW = 16;
    localparam int CW = 7;
    localparam int OW = 6;
    localparam int XAW = 12;
    localparam int GFRAC = 14;
    localparam int XP_DEPTH = N_OUT * N_SRC;
    localparam logic [XAW-1:0] XP_STRIDE = 12'h048;
    localparam logic [XAW-1:0] XP_LAST = 12'hA1F;
    localparam logic [GW-1:0] GAIN_UNITY = 16'h4000;
    localparam logic [GW-1:0] GAIN_MINUS_INF = 16'h0000;
    localparam logic [7:0] PAN_CENTER = 8'h80;
    localparam logic [8:0] PAN_SPAN = 9'h100;
    // Pan law g(x) = x * (A - B*x), with g(1) = 1 and g(0.5) = -3 dB.
    localparam logic [14:0] PAN_A = 15'h7504;
    localparam logic [14:0] PAN_B = 15'h3505;
    localparam logic [14:0] PAN_G_CENTER = 15'h2D41;
    localparam logic [22:0] FULL_SCALE = 23'h7FFFFF;
    localparam logic [SW-1:0] POS_MAX = 24'h7FFFFF;
    localparam logic [SW-1:0] NEG_MAX = 24'h800000;
    localparam logic [3:0] OVER_RUN_MAX = 4'hF;
    localparam int MS_SHIFT = 6;

    typedef struct packed {
        logic mute;
        logic stereo;
        logic trim_en;
        logic [7:0] pan;
        logic [GW-1:0] trim;
    } mam_src_cfg_type;

    typedef struct packed {
        logic stereo;
        logic loopback;
        logic [GW-1:0] gain;
    } mam_out_cfg_type;

    typedef struct packed {
        logic [22:0] peak;
        logic [15:0] hold;
        logic [3:0] over_run;
        logic over;
        logic [31:0] ms;
    } mam_meter_state_type;

    typedef struct packed {
        logic [22:0] peak;
        logic [31:0] average_power_level;
        logic overload_indicator;
    } mam_meter_type;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_MIX = 3'b010,
        ST_FIN = 3'b011,
        ST_METER = 3'b100
    } mam_state_type;

    localparam mam_src_cfg_type SRC_CFG_RST = '{1'b0, 1'b0, 1'b0,
        PAN_CENTER, GAIN_UNITY};
    localparam mam_out_cfg_type OUT_CFG_RST = '{1'b0, 1'b0, GAIN_UNITY};
endpackage

//--- testbench/mam_core_tb_top.sv
`timescale 1ns/10ps
module mam_core_tb_top;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic start = 1'b0;
    logic frame_go = 1'b0;
    logic gain_wr = 1'b0;
    logic src_cfg_wr = 1'b0;
    logic out_cfg_wr = 1'b0;
    logic [72*24-1:0] smp = '0;
    logic [5:0] gain_out = 6'h00;
    logic [5:0] out_sel = 6'h00;
    logic [6:0] gain_src = 7'h00;
    logic [6:0] src_sel = 7'h00;
    logic [15:0] gain_val = 16'h0000;
    mam_pkg::mam_src_cfg_type src_cfg = mam_pkg::SRC_CFG_RST;
    mam_pkg::mam_out_cfg_type out_cfg = mam_pkg::OUT_CFG_RST;
    logic busy, in_ready, in_valid, init_done;
    logic out_valid, rec_valid, meter_valid;
    logic [6:0] in_chan, meter_chan;
    logic [5:0] out_chan, rec_chan;
    logic [23:0] in_sample, out_sample, rec_sample;
    mam_pkg::mam_meter_type meter;
    int xp[36][72];
    int sv[72];
    int tr[72];
    int og[36];
    bit mu[72], te[72], ost[36], olb[36];
    longint eo[36];
    int n_out = 0, n_rec = 0, n_met = 0, i, k, m;
    int pk[108], hd[108];
    bit ov[108], ss[72];
    longint v, pw[108];
    logic [15:0] hold = 16'h0000;
    logic rp = 1'b0;
    int mismatches = 0, samples_checked = 0;

    always #25 clock = ~clock;

    mam_src_model i_mam_src_model (.clock(clock), .arst_n(arst_n),
        .start(start), .smp(smp), .busy(busy), .in_ready(in_ready),
        .in_valid(in_valid), .in_chan(in_chan), .in_sample(in_sample));

    mam_core i_mam_core (.clock(clock), .arst_n(arst_n), .ce(1'b1),
        .in_valid(in_valid), .in_chan(in_chan), .in_sample(in_sample),
        .in_ready(in_ready), .frame_go(frame_go), .gain_wr(gain_wr),
        .gain_out(gain_out), .gain_src(gain_src), .gain_val(gain_val),
        .src_cfg_wr(src_cfg_wr), .src_sel(src_sel), .src_cfg(src_cfg),
        .out_cfg_wr(out_cfg_wr), .out_sel(out_sel), .out_cfg(out_cfg),
        .hold_frames(hold), .over_samples(4'h1),
        .rms_ref_plus3(rp), .init_done(init_done),
        .out_valid(out_valid), .out_chan(out_chan),
        .out_sample(out_sample), .rec_valid(rec_valid),
        .rec_chan(rec_chan), .rec_sample(rec_sample),
        .meter_valid(meter_valid), .meter_chan(meter_chan), .meter(meter));

    function automatic longint sat(longint v);
        return v > 8388607 ? 8388607 : (v < -8388608 ? -8388608 : v);
    endfunction

    function automatic int mag(longint v);
        return v == -8388608 ? 8388607 : (v < 0 ? -v : v);
    endfunction

    task automatic compute();
        longint acc, c;
        for (int o = 0; o < 36; o++) begin
            acc = 0;
            for (int s = 0; s < 72; s++) begin
                c = mu[s] ? 0 : xp[o][s];
                if (te[s]) c = (c * tr[s]) >>> 14;
                if (ost[o] && !ss[s]) c = (c * 16'h2D41) >>> 14;
                if (ost[o] && ss[s] && s % 2 != o % 2) c = 0;
                acc += (sv[s] * c) >>> 14;
            end
            eo[o] = sat((acc * og[o]) >>> 14);
        end
    endtask

    task automatic check(logic [31:0] got, logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic test_done();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wsrc(int s);
        @(posedge clock);
        src_cfg_wr <= 1'b1;
        src_sel <= 7'(s);
        src_cfg <= '{mu[s], ss[s], te[s], mam_pkg::PAN_CENTER, 16'(tr[s])};
        @(posedge clock);
        src_cfg_wr <= 1'b0;
    endtask

    task automatic wout(int o);
        @(posedge clock);
        out_cfg_wr <= 1'b1;
        out_sel <= 6'(o);
        out_cfg <= '{ost[o], olb[o], 16'(og[o])};
        @(posedge clock);
        out_cfg_wr <= 1'b0;
    endtask

    task automatic wgain(int o, int s);
        @(posedge clock);
        gain_wr <= 1'b1;
        gain_out <= 6'(o);
        gain_src <= 7'(s);
        gain_val <= 16'(xp[o][s]);
        @(posedge clock);
        gain_wr <= 1'b0;
    endtask

    task automatic frame(int f);
        for (int s = 0; s < 72; s++) smp[s*24 +: 24] = 24'(sv[s]);
        compute();
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (busy !== 1'b0 && i < 200);
        frame_go <= 1'b1;
        @(posedge clock);
        frame_go <= 1'b0;
        i = 0;
        while (n_met < 108 * f && i < 6000) begin
            @(posedge clock);
            i++;
        end
    endtask

    // Results are judged in the cycle their strobe stands.
    always @(posedge clock) begin
        if (arst_n && out_valid) begin
            check({26'h0, out_chan}, 32'(n_out % 36));
            n_out++;
            check({8'h00, out_sample}, {8'h00, 24'(eo[out_chan])});
        end
        if (arst_n && rec_valid) begin
            check({26'h0, rec_chan}, 32'(n_rec % 36));
            n_rec++;
            check({8'h00, rec_sample}, {8'h00, olb[rec_chan] ?
                24'(eo[rec_chan]) : 24'(sv[rec_chan])});
        end
        if (arst_n && meter_valid) begin
            check({25'h0, meter_chan}, 32'(n_met % 108));
            n_met++;
            k = meter_chan;
            v = k < 72 ? sv[k] : eo[k - 72];
            m = mag(v);
            // The over flag outlives its sample only while a hold runs.
            ov[k] = m == 8388607 || (ov[k] && hd[k] != 0);
            if (m >= pk[k]) begin
                pk[k] = m;
                hd[k] = hold;
            end else if (hd[k] != 0) begin
                hd[k]--;
            end else begin
                pk[k] = m;
            end
            pw[k] += (((v * v) >> 15) - pw[k]) >>> 6;
            check({9'h000, meter.peak}, 32'(pk[k]));
            check({31'h0, meter.overload_indicator}, {31'h0, ov[k]});
            check(meter.average_power_level, !rp ? 32'(pw[k]) :
                (pw[k] > 'h7FFFFFFF ? 32'hFFFFFFFF : 32'(pw[k] * 2)));
        end
    end

    initial begin
        void'($urandom(32'h732F));
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        i = 0;
        while (init_done !== 1'b1 && i < 3000) begin
            @(posedge clock);
            i++;
        end
        // Muting, trim and pan centre all meet on the first outputs.
        for (int s = 0; s < 72; s++) begin
            mu[s] = (s == 4);
            te[s] = (s == 5 || s == 40);
            tr[s] = te[s] ? 'h2000 : 'h4000;
            wsrc(s);
        end
        for (int o = 0; o < 36; o++) begin
            ost[o] = (o < 2);
            olb[o] = (o == 3);
            og[o] = (o == 2) ? 'h6000 : ((o == 5) ? 0 : 'h4000);
            wout(o);
        end
        for (int o = 0; o < 36; o++)
            for (int s = 0; s < 72; s++) xp[o][s] = 0;
        for (int o = 0; o < 6; o++)
            for (int s = 0; s < 72; s++) begin
                xp[o][s] = (o == 4) ? 'h7FFF :
                    (($urandom % 4 == 0) ? 0 : $urandom % 'h8000);
                wgain(o, s);
            end
        // Frame 2 arms the peak hold and the +3 dB reference, so frame 3
        // meets held peaks; frame 3 also puts stereo sources on the pair.
        for (int f = 1; f < 4; f++) begin
            for (int s = 0; s < 72; s++)
                sv[s] = int'($urandom % 32'h1000000) - 8388608;
            if (f == 1) sv[7] = -8388608;
            else if (f == 2) begin
                tr[5] = 'h6000;
                wsrc(5);
                hold <= 16'h0002;
                rp <= 1'b1;
            end else begin
                ss[6] = 1'b1;
                ss[9] = 1'b1;
                wsrc(6);
                wsrc(9);
            end
            frame(f);
        end
        check(32'(n_out), 32'd108);
        check(32'(n_rec), 32'd108);
        check(32'(n_met), 32'd324);
        test_done();
    end

    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        test_done();
    end
endmodule

//--- testbench/mam_src_model.sv
`timescale 1ns/10ps
module mam_src_model (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Bench control
    input wire logic start,
    input wire logic [72*24-1:0] smp,
    output logic busy,
    // Source stream
    input wire logic in_ready,
    output logic in_valid,
    output logic [6:0] in_chan,
    output logic [23:0] in_sample
);
    // Every source of the frame is sent once, inputs then playback.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            in_valid <= 1'b0;
            in_chan <= 7'h00;
            in_sample <= 24'h000000;
        end else if (start && !busy) begin
            busy <= 1'b1;
            in_valid <= 1'b1;
            in_chan <= 7'h00;
            in_sample <= smp[23:0];
        end else if (busy && in_ready) begin
            if (in_chan == 7'h47) begin
                busy <= 1'b0;
                in_valid <= 1'b0;
                in_sample <= ~in_sample;
            end else begin
                in_chan <= in_chan + 7'h01;
                in_sample <= smp[(int'(in_chan) + 1) * 24 +: 24];
            end
        end else if (!busy) begin
            // A released line must not look like a stale sample.
            in_sample <= ~in_sample;
        end
    end
endmodule
